// ==== verif/elm_chk.sv ====
// port assertions for the link integrity monitor
`timescale 1ns/1ps
module elm_chk #(
  parameter int unsigned BEAT_PERIOD = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_en_i,
  input wire logic rx_msg_valid_i,
  input wire logic tp_receive_active_i,
  input wire logic aui_collision_pair_i,
  input wire logic aui_receive_pair_i,
  input wire logic tx_allowed_o,
  input wire logic rx_allowed_o,
  input wire logic col_allowed_o,
  input wire logic loopback_allowed_o,
  input wire logic tx_active_o,
  input wire logic rx_active_o,
  input wire logic collision_active_o,
  input wire logic link_beat_o,
  input wire logic link_status_o,
  input wire logic link_led_output_o,
  input wire logic half_squelch_o,
  input wire logic internal_collision_o,
  input wire logic rx_clock_locked_o,
  input wire logic rx_strobe_o,
  input wire logic rx_data_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  int unsigned gap;
  // clocks since the last beat while the transmit path idles
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_en_i || link_beat_o) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  sequence col_rise;
    $rose(aui_collision_pair_i) && col_allowed_o;
  endsequence
  sequence col_quiet;
    !aui_collision_pair_i [*4];
  endsequence
  hw_reset_a: assert property ($fell(rst_i) |-> !link_status_o && !tx_allowed_o)
    else $error("link not failed after reset");
  pass_gates_a: assert property (link_status_o |-> tx_allowed_o && rx_allowed_o && col_allowed_o)
    else $error("paths gated in link pass");
  fail_quiet_a: assert property (!tx_allowed_o |-> !tx_active_o && !rx_active_o && !collision_active_o &&
    !rx_allowed_o && !loopback_allowed_o)
    else $error("activity shown in link fail");
  led_follow_a: assert property (link_led_output_o == link_status_o)
    else $error("led differs from link status");
  msg_pass_a: assert property (rx_msg_valid_i && !link_status_o |-> ##[1:2] link_status_o)
    else $error("message did not pass the link");
  beat_idle_a: assert property (tx_en_i [*2] |=> !link_beat_o)
    else $error("beat during transmit");
  beat_gap_a: assert property (gap <= 2 * BEAT_PERIOD + 4)
    else $error("beat interval too long");
  half_squelch_a: assert property (half_squelch_o == tp_receive_active_i)
    else $error("squelch not halved in reception");
  col_set_a: assert property (col_rise |-> ##1 internal_collision_o [*3])
    else $error("collision not raised");
  col_clear_a: assert property (col_quiet |-> !internal_collision_o)
    else $error("collision held too long");
  lock_fall_a: assert property ($rose(rx_clock_locked_o) |-> !$past(aui_receive_pair_i) &&
    $past(aui_receive_pair_i, 2))
    else $error("clock locked without a falling edge");
  strobe_data_a: assert property (rx_strobe_o |-> rx_clock_locked_o && rx_data_o == $past(aui_receive_pair_i))
    else $error("strobe without lock or wrong data");
endmodule
bind elm_top elm_chk #(.BEAT_PERIOD(BEAT_PERIOD)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .tx_en_i(tx_en_i),
  .rx_msg_valid_i(rx_msg_valid_i), .tp_receive_active_i(tp_receive_active_i), .tx_allowed_o(tx_allowed_o),
  .aui_collision_pair_i(aui_collision_pair_i), .aui_receive_pair_i(aui_receive_pair_i),
  .rx_allowed_o(rx_allowed_o), .col_allowed_o(col_allowed_o), .loopback_allowed_o(loopback_allowed_o),
  .tx_active_o(tx_active_o), .rx_active_o(rx_active_o), .collision_active_o(collision_active_o),
  .link_beat_o(link_beat_o), .link_status_o(link_status_o), .link_led_output_o(link_led_output_o),
  .half_squelch_o(half_squelch_o), .internal_collision_o(internal_collision_o),
  .rx_clock_locked_o(rx_clock_locked_o), .rx_strobe_o(rx_strobe_o), .rx_data_o(rx_data_o));

// ==== verif/elm_line.sv ====
// line partner: link beats, aui loopback and collision signalling
`timescale 1ns/1ps
module elm_line (
  input wire logic clk_i,
  input wire logic tx_en_i,
  input wire logic [15:0] goal_i,
  input wire logic pol_i,
  input wire logic loop_on_i,
  input wire logic col_on_i,
  output logic [15:0] sent_o,
  output logic beat_o,
  output logic pol_o,
  output logic aui_rx_o,
  output logic aui_col_o
);
  logic [2:0] slot = 3'h0;
  logic half = 1'b0;
  logic [15:0] sent = 16'h0000;
  logic beat = 1'b0;
  logic pol = 1'b0;
  logic rx = 1'b0;
  logic col = 1'b0;
  assign sent_o = sent;
  assign beat_o = beat;
  assign pol_o = pol;
  assign aui_rx_o = rx;
  assign aui_col_o = col;
  // one beat in every eight clocks until the count the bench asked for is sent
  always @(posedge clk_i) begin
    slot <= slot + 3'h1;
    beat <= 1'b0;
    pol <= pol_i;
    if (slot == 3'h7 && sent < goal_i) begin
      beat <= 1'b1;
      sent <= sent + 16'h0001;
    end
  end
  // the mau echoes transmit activity as alternating bits; an idle pair rests low
  always @(posedge clk_i) begin
    half <= ~half;
    if (loop_on_i && tx_en_i) begin
      rx <= half ? ~rx : rx;
    end else begin
      rx <= 1'b0;
    end
    col <= col_on_i ? ~col : 1'b0;
  end
endmodule

// ==== verif/elm_top_test.sv ====
// self-checking bench for the link integrity monitor
`timescale 1ns/1ps
module elm_top_test
  import elm_pkg::*;
;
  localparam int BP = 20;
  localparam int LP = 100;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, soft_reset_i = 0, tx_en_i = 0;
  logic tp_receive_active_i = 0, rx_msg_valid_i = 0, wb_ack_o, irq_o, link_status_o, link_led_output_o;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, seed = 32'h08322686;
  logic link_beat_i, link_beat_pol_i, aui_receive_pair_i, aui_collision_pair_i, link_beat_o;
  logic tx_allowed_o, low_receive_threshold_o, loss_of_carrier_o, internal_collision_o;
  logic [31:0] expq[$];
  logic [15:0] beat_goal = 16'h0000, beat_sent;
  logic beat_pol = 0, loop_on = 0, col_on = 0;
  int err_total = 0, samples_checked = 0, nbeat = 0, n0;
  always #25 clk_i = ~clk_i;
  elm_line ln (.clk_i, .tx_en_i, .goal_i(beat_goal), .pol_i(beat_pol), .loop_on_i(loop_on), .col_on_i(col_on),
    .sent_o(beat_sent), .beat_o(link_beat_i), .pol_o(link_beat_pol_i), .aui_rx_o(aui_receive_pair_i),
    .aui_col_o(aui_collision_pair_i));
  elm_top #(.BEAT_PERIOD(BP), .LOSS_PERIOD(LP)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .soft_reset_i, .tx_en_i, .tx_allowed_o, .rx_allowed_o(),
    .col_allowed_o(), .loopback_allowed_o(), .loss_of_carrier_o, .tx_active_o(), .rx_active_o(),
    .collision_active_o(), .link_beat_i, .link_beat_pol_i, .tp_receive_active_i, .rx_msg_valid_i,
    .aui_receive_pair_i, .aui_collision_pair_i, .link_beat_o, .link_status_o, .link_led_output_o,
    .low_receive_threshold_o, .half_squelch_o(), .internal_collision_o, .rx_clock_locked_o(), .rx_strobe_o(),
    .rx_data_o());
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one classic cycle; a read leaves its expected data for the monitor
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    if (!we) expq.push_back(dat);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic beats(input int n, input logic pol);
    beat_pol <= pol;
    beat_goal <= beat_sent + 16'(n);
    @(posedge clk_i);
    if (n < 100) wait (beat_sent >= beat_goal);
    tick(4);
  endtask
  task automatic frame(input int lc, input logic [31:0] loss_of_carrier);
    tx_en_i <= 1;
    loop_on <= lc > 0;
    tick(lc);
    loop_on <= 0;
    tick(40 - lc);
    tx_en_i <= 0;
    tick(4);
    chk(loss_of_carrier_o, loss_of_carrier[11]);
    wb(0, REG_TXSTAT, loss_of_carrier);
  endtask
  always @(posedge clk_i) begin
    if (link_beat_o === 1'b1) nbeat++;
    if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, expq.pop_front());
  end
  initial begin
    tick(20000);
    err_total++;
    results();
  end
  initial begin
    tick(3);
    rst_i <= 0;
    tick(1);
    wb(0, REG_STATUS, 32'h0);
    chk(tx_allowed_o, 0);
    wb(0, 8'h20, 32'h0);
    beats(3, 0);
    beats(5, 1);
    wb(0, REG_STATUS, 32'h0);
    beats(1, 1);
    wb(0, REG_STATUS, 32'h1);
    chk(link_led_output_o, 1);
    beats(1000, 1);
    repeat (60) begin
      @(posedge clk_i);
      seed = xs(seed);
      soft_reset_i <= seed[0];
      tp_receive_active_i <= seed[1];
    end
    soft_reset_i <= 0;
    tp_receive_active_i <= 0;
    wb(0, REG_STATUS, 32'h1);
    beats(0, 1);
    tick(2 * LP + 30);
    wb(0, REG_STATUS, 32'h0);
    chk(tx_allowed_o, 0);
    wb(1, REG_MODE, 32'h1000);
    n0 = nbeat;
    chk(tx_allowed_o, 1);
    tick(2 * LP + 30);
    chk(nbeat - n0 >= (2 * LP + 30) / (2 * BP) - 1, 1);
    rx_msg_valid_i <= 1;
    tick(1);
    rx_msg_valid_i <= 0;
    tick(3);
    wb(0, REG_STATUS, 32'h1);
    wb(1, REG_MODE, 32'h1201);
    chk(low_receive_threshold_o, 1);
    wb(0, REG_MODE, 32'h1201);
    col_on <= 1;
    tick(20);
    col_on <= 0;
    tick(10);
    wb(0, REG_INT, 32'h9);
    frame(40, 32'h0);
    frame(10, 32'h800);
    frame(0, 32'h800);
    chk(irq_o, 0);
    wb(1, REG_MASK, 32'h4);
    chk(irq_o, 1);
    wb(0, REG_INT, 32'h4);
    chk(irq_o, 0);
    results();
  end
endmodule

// ==== verilog/elm_pkg.sv ====
// constants, register map and rule summary for the ethernet link integrity monitor
// What this block does
// [R01] with link testing on, enter link fail when no beats or data are seen
// [R02] link fail gates transmit, receive, loopback and collision until data or over 5 beats
// [R03] link status low in link fail, high with the link led once link is good
// [R04] hardware reset forces link fail
// [R05] software reset leaves the link state and link test state alone
// [R06] with link test disabled, all paths stay enabled regardless of line activity
// [R07] link beats are sent whatever link test disable holds
// [R08] idle transmit path emits periodic link beats
// [R09] low receive threshold, mode bit 9, selects the more sensitive receive threshold
// [R10] after unsquelch the squelch threshold halves until reception ends
// [R11] aui collision drives internal collision, held 1.5 bit times after last rise
// [R12] clock acquired after 1010 pattern, locking on the second zero mid-cell fall
// [R13] bits sampled at quarter bit; transitions a quarter bit off decode wrongly
// [R14] on aui, looped-back receive data gives internal carrier sense during transmit
// [R15] carrier never seen or lost during transmit sets loss of carrier after the frame
// [R16] leave link fail after 5 to 6 same-polarity beats or one message, enter link pass
// [R17] in link fail, internal transmit, receive and collision indications are inactive
// [R18] link beats about every 16 ms from the 10 MHz bit clock while idle
// [R19] link loss timeout of roughly 50 to 150 ms without beats or data
package elm_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BIT_HZ = 10000000;
  localparam int unsigned BEAT_MS = 16;
  localparam int unsigned LOSS_MS = 100;
  localparam int unsigned BEAT_BITS = BIT_HZ / 1000 * BEAT_MS;
  localparam int unsigned LOSS_BITS = BIT_HZ / 1000 * LOSS_MS;
  localparam int unsigned BEATS_TO_PASS = 5;
  // half-bit counts at the 20 MHz clock
  localparam logic [3:0] COL_HOLD_HALVES = 4'h3;
  localparam logic [3:0] ACQ_EDGES = 4'h4;
  localparam logic [3:0] QUARTER_CLKS = 4'h1;
  // wishbone register byte offsets
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_TXSTAT = 8'h10;
  // mode register fields
  localparam int unsigned MODE_LRT_BIT = 9;
  localparam int unsigned MODE_DLT_BIT = 12;
  localparam int unsigned MODE_AUI_BIT = 0;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam int unsigned TX_LOSS_OF_CARRIER_BIT = 11;
  // interrupt bits
  localparam int unsigned IRQ_FAIL = 0;
  localparam int unsigned IRQ_PASS = 1;
  localparam int unsigned IRQ_LOSS_OF_CARRIER = 2;
  localparam int unsigned IRQ_COL = 3;
  localparam int unsigned IRQ_W = 4;
  typedef enum logic [0:0] {
    LINK_FAIL = 1'b0,
    LINK_PASS = 1'b1
  } elm_link_t;
endpackage

// ==== verilog/elm_top.sv ====
// link test, aui collision, clock acquisition and loss of carrier logic
`timescale 1ns/1ps
module elm_top
  import elm_pkg::*;
#(
  parameter int unsigned BEAT_PERIOD = BEAT_BITS,
  parameter int unsigned LOSS_PERIOD = LOSS_BITS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // mac side
  input wire logic soft_reset_i,
  input wire logic tx_en_i,
  output logic tx_allowed_o,
  output logic rx_allowed_o,
  output logic col_allowed_o,
  output logic loopback_allowed_o,
  output logic loss_of_carrier_o,
  output logic tx_active_o,
  output logic rx_active_o,
  output logic collision_active_o,
  // line side, already qualified by the analog front end
  input wire logic link_beat_i,
  input wire logic link_beat_pol_i,
  input wire logic tp_receive_active_i,
  input wire logic rx_msg_valid_i,
  input wire logic aui_receive_pair_i,
  input wire logic aui_collision_pair_i,
  output logic link_beat_o,
  output logic link_status_o,
  output logic link_led_output_o,
  output logic low_receive_threshold_o,
  output logic half_squelch_o,
  output logic internal_collision_o,
  output logic rx_clock_locked_o,
  output logic rx_strobe_o,
  output logic rx_data_o
);
  elm_link_t link_reg;
  logic [31:0] mode_reg;
  logic [IRQ_W-1:0] int_reg;
  logic [IRQ_W-1:0] mask_reg;
  logic loss_of_carrier_reg;
  logic bit_en_reg;
  logic [31:0] beat_cnt_reg;
  logic [31:0] loss_cnt_reg;
  logic [2:0] beat_seen_reg;
  logic last_pol_reg;
  logic [3:0] col_cnt_reg;
  logic col_prev_reg;
  logic aui_prev_reg;
  logic [3:0] acq_cnt_reg;
  logic [1:0] phase_reg;
  logic sense_reg;
  logic sense_seen_reg;
  logic sense_lost_reg;
  logic tx_prev_reg;
  logic link_prev_reg;
  logic [3:0] idle_cnt_reg;
  logic link_test_disable;
  logic aui_sel;
  logic link_ok;
  logic wb_req;
  logic rd_int;
  logic [IRQ_W-1:0] ev;
  logic beat_good;
  logic frame_end;

  assign link_test_disable = mode_reg[MODE_DLT_BIT];
  assign aui_sel = mode_reg[MODE_AUI_BIT];
  assign low_receive_threshold_o = mode_reg[MODE_LRT_BIT]; // [R09]
  assign link_ok = link_test_disable || (link_reg == LINK_PASS); // [R06]
  assign tx_allowed_o = link_ok; // [R02]
  assign rx_allowed_o = link_ok; // [R02]
  assign col_allowed_o = link_ok; // [R02]
  assign loopback_allowed_o = link_ok; // [R02]
  assign tx_active_o = link_ok && tx_en_i; // [R17]
  assign rx_active_o = link_ok && tp_receive_active_i; // [R17]
  assign collision_active_o = link_ok && tx_en_i && tp_receive_active_i; // [R17]
  assign link_status_o = (link_reg == LINK_PASS); // [R03]
  assign link_led_output_o = link_status_o; // [R03]
  assign half_squelch_o = tp_receive_active_i; // [R10]
  assign loss_of_carrier_o = loss_of_carrier_reg;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_int = wb_req && !wb_we_i && (wb_adr_i == REG_INT);
  assign irq_o = |(int_reg & mask_reg);
  assign beat_good = link_beat_i && (beat_seen_reg == 3'h0 || link_beat_pol_i == last_pol_reg);
  assign frame_end = tx_prev_reg && !tx_en_i;

  // bit clock enable derived from the 20 MHz reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_en_reg <= 1'b0;
    end else begin
      bit_en_reg <= !bit_en_reg;
    end
  end

  // link beat generator, independent of link test disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      beat_cnt_reg <= 32'h0000_0000;
      link_beat_o <= 1'b0;
    end else begin
      link_beat_o <= 1'b0;
      if (tx_en_i) begin
        beat_cnt_reg <= 32'h0000_0000; // [R08]
      end else if (bit_en_reg) begin
        if (beat_cnt_reg >= BEAT_PERIOD - 1) begin
          beat_cnt_reg <= 32'h0000_0000;
          link_beat_o <= 1'b1; // [R07] [R18]
        end else begin
          beat_cnt_reg <= beat_cnt_reg + 32'h0000_0001;
        end
      end
    end
  end

  // link state machine; soft reset is deliberately not an input here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_reg <= LINK_FAIL; // [R04]
      loss_cnt_reg <= 32'h0000_0000;
      beat_seen_reg <= 3'h0;
      last_pol_reg <= 1'b0;
    end else begin // [R05]
      case (link_reg)
        LINK_FAIL: begin
          loss_cnt_reg <= 32'h0000_0000;
          if (rx_msg_valid_i) begin
            link_reg <= LINK_PASS; // [R16]
            beat_seen_reg <= 3'h0;
          end else if (link_beat_i) begin
            last_pol_reg <= link_beat_pol_i;
            if (!beat_good) begin
              beat_seen_reg <= 3'h1;
            end else if (beat_seen_reg == 3'(BEATS_TO_PASS)) begin
              link_reg <= LINK_PASS; // [R02] [R16]
              beat_seen_reg <= 3'h0;
            end else begin
              beat_seen_reg <= beat_seen_reg + 3'h1;
            end
          end
        end
        LINK_PASS: begin
          if (link_beat_i || tp_receive_active_i) begin
            loss_cnt_reg <= 32'h0000_0000;
          end else if (bit_en_reg) begin
            if (loss_cnt_reg >= LOSS_PERIOD - 1) begin
              loss_cnt_reg <= 32'h0000_0000;
              if (!link_test_disable) begin
                link_reg <= LINK_FAIL; // [R01] [R19]
              end
            end else begin
              loss_cnt_reg <= loss_cnt_reg + 32'h0000_0001;
            end
          end
        end
        default: link_reg <= LINK_FAIL;
      endcase
    end
  end

  // collision stretch: held three half bits after the last rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_prev_reg <= 1'b0;
      col_cnt_reg <= 4'h0;
      internal_collision_o <= 1'b0;
    end else begin
      col_prev_reg <= aui_collision_pair_i;
      if (!col_allowed_o) begin
        col_cnt_reg <= 4'h0;
        internal_collision_o <= 1'b0;
      end else if (aui_collision_pair_i && !col_prev_reg) begin
        col_cnt_reg <= COL_HOLD_HALVES;
        internal_collision_o <= 1'b1; // [R11]
      end else if (col_cnt_reg > 4'h1) begin
        col_cnt_reg <= col_cnt_reg - 4'h1;
      end else begin
        // high for exactly three clocks after the last rise, 1.5 bit times
        col_cnt_reg <= 4'h0;
        internal_collision_o <= 1'b0; // [R11]
      end
    end
  end

  // clock acquisition on 1010 and quarter-bit sampling of the aui receive pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aui_prev_reg <= 1'b0;
      acq_cnt_reg <= 4'h0;
      phase_reg <= 2'h0;
      idle_cnt_reg <= 4'h0;
      rx_clock_locked_o <= 1'b0;
      rx_strobe_o <= 1'b0;
      rx_data_o <= 1'b1;
    end else begin
      aui_prev_reg <= aui_receive_pair_i;
      rx_strobe_o <= 1'b0;
      if (aui_receive_pair_i != aui_prev_reg) begin
        idle_cnt_reg <= 4'h0;
      end else if (idle_cnt_reg != 4'hF) begin
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
      end
      if (idle_cnt_reg == 4'hF || !rx_allowed_o) begin
        acq_cnt_reg <= 4'h0;
        rx_clock_locked_o <= 1'b0;
        phase_reg <= 2'h0;
      end else if (!rx_clock_locked_o) begin
        if (aui_prev_reg && !aui_receive_pair_i) begin
          if (acq_cnt_reg == 4'h1) begin
            rx_clock_locked_o <= 1'b1; // [R12]
            phase_reg <= 2'h0;
          end
          acq_cnt_reg <= acq_cnt_reg + 4'h1;
        end
      end else begin
        if (aui_receive_pair_i != aui_prev_reg) begin
          phase_reg <= 2'h0;
        end else begin
          phase_reg <= phase_reg + 2'h1;
        end
        if (phase_reg == 2'(QUARTER_CLKS)) begin
          rx_strobe_o <= 1'b1; // [R13]
          rx_data_o <= aui_receive_pair_i;
        end
      end
    end
  end

  // looped-back carrier sense and loss of carrier flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_prev_reg <= 1'b0;
      sense_reg <= 1'b0;
      sense_seen_reg <= 1'b0;
      sense_lost_reg <= 1'b0;
      loss_of_carrier_reg <= 1'b0;
    end else begin
      tx_prev_reg <= tx_en_i;
      sense_reg <= aui_sel && tx_en_i && (idle_cnt_reg != 4'hF); // [R14]
      if (tx_en_i && !tx_prev_reg) begin
        sense_seen_reg <= 1'b0;
        sense_lost_reg <= 1'b0;
        loss_of_carrier_reg <= 1'b0;
      end else if (tx_en_i) begin
        if (sense_reg) begin
          sense_seen_reg <= 1'b1;
        end else if (sense_seen_reg) begin
          sense_lost_reg <= 1'b1;
        end
      end
      if (frame_end && aui_sel && (!sense_seen_reg || sense_lost_reg)) begin
        loss_of_carrier_reg <= 1'b1; // [R15]
      end
    end
  end

  // register file: mode, status, interrupt, mask, transmit status word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_RESET;
      mask_reg <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == REG_MODE) begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
              mode_reg[8*i +: 8] <= wb_dat_i[8*i +: 8];
            end
          end
        end else if (wb_adr_i == REG_MASK && wb_sel_i[0]) begin
          mask_reg <= wb_dat_i[IRQ_W-1:0];
        end
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          REG_MODE: wb_dat_o <= mode_reg;
          REG_STATUS: wb_dat_o <= {29'h0, internal_collision_o, rx_clock_locked_o, link_status_o};
          REG_INT: wb_dat_o <= {28'h0, int_reg};
          REG_MASK: wb_dat_o <= {28'h0, mask_reg};
          REG_TXSTAT: wb_dat_o <= {20'h0, loss_of_carrier_reg, 11'h0};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // sticky events, cleared by reading; a new event wins over the read
  always_comb begin
    ev = '0;
    ev[IRQ_FAIL] = link_prev_reg && !link_status_o; // [R01]
    ev[IRQ_PASS] = 1'b0;
    ev[IRQ_LOSS_OF_CARRIER] = frame_end && aui_sel && (!sense_seen_reg || sense_lost_reg);
    ev[IRQ_COL] = aui_collision_pair_i && !col_prev_reg && col_allowed_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_reg <= '0;
    end else begin
      int_reg <= ((rd_int ? '0 : int_reg) | ev);
    end
  end

  // previous link status, so a drop from link pass raises the link lost event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_prev_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_status_o;
    end
  end
endmodule
